// ### hw/acs_top.sv
// Summary of operation
// - Start on internal oscillator, then hand over.
// - Count external clock falling edges; need 59 in a 50 us window.
// - Failed check: stay internal, flag error.
// - Fault state outputs nothing; reset only exit.
// - Strap low selects single-ended clock input.
// - Strap high selects crystal or differential input.
// - Differential clock only in serial-port mode.
// - Pin input low plus bit write enables differential.
// - Register 0x05 sets common-mode output enable, level.
// - Channel 0 standby disables common-mode output.
// - Strap mode: common-mode half supply, precharge off.
// - Filter type per channel, or shared in strap.
// - Six decimation rates for each filter type.
`timescale 1ns/1ps
`include "acs_map.svh"
`default_nettype none
module acs_top
  import acs_pkg::*;
#(
  parameter int NCH = 8
)
(
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           mclk_pin,
  input  wire logic           clk_sel_pin,
  input  wire logic           ctrl_mode_pin,
  input  wire logic           filter_pin,
  input  wire logic [2:0]     decim_pin,
  input  wire logic           diff_clock_mode_pin_i,
  output logic                diff_clock_mode_pin_o,
  output logic                diff_clock_mode_pin_oe,
  input  wire logic           sclk,
  input  wire logic           cs_n,
  input  wire logic           sdi,
  output logic                sdo,
  output logic                sdo_oe,
  output logic                ext_clk_sel,
  output logic                clk_err,
  output logic                status_hdr_err,
  output logic                conv_data_en,
  output logic                diff_clk_en,
  output logic                xtal_excite_en,
  output logic                common_mode_output_en,
  output logic [1:0]          common_mode_output_level,
  output logic [7:0]          ref_prechg_en,
  output logic [NCH-1:0]      filter_type,
  output logic [2:0]          decim_sel,
  output logic [NCH-1:0]      chan_standby
);
  localparam int XCH = (NCH == 8) ? 4 : 2;

  initial
  begin
    if (NCH != 8 && NCH != 4) $error("acs_top supports four or eight channels.");
  end

  function automatic logic decim_ok(input logic [2:0] v);
    decim_ok = (v <= `ACS_DECIM_MAX);
  endfunction

  logic rst_s1_ff;
  logic rst_s2_ff;
  wire  rst_core_n = rst_s2_ff;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  logic [10:0] pins_l;
  acs_sync3 #(.W(11), .RST_VAL(11'h400)) u_sync (
    .clock (clock),
    .rst_n (rst_core_n),
    .d     ({cs_n, sclk, sdi, mclk_pin, clk_sel_pin, ctrl_mode_pin, filter_pin, decim_pin,
             diff_clock_mode_pin_i}),
    .q     (pins_l)
  );
  wire       cs_l     = pins_l[10];
  wire       sclk_l   = pins_l[9];
  wire       sdi_l    = pins_l[8];
  wire       mclk_l   = pins_l[7];
  wire       clksel_l = pins_l[6];
  wire       ctrl_l   = pins_l[5];
  wire       filt_l   = pins_l[4];
  wire [2:0] decim_l  = pins_l[3:1];
  wire       dpin_l   = pins_l[0];

  acs_state_t  state_ff;
  acs_state_t  nxt_state;
  logic [15:0] startup_cnt_ff;
  logic        strap_done_ff;
  logic        clk_sel_ff;
  logic        spi_mode_ff;
  logic        qual_start_ff;
  logic        qual_done;
  logic        qual_pass;
  wire         startup_end = (state_ff == ACS_ST_STARTUP)
                           && (startup_cnt_ff == 16'(`ACS_STARTUP_CYC - 1));

  acs_clk_qual u_qual (
    .clock    (clock),
    .rst_n    (rst_core_n),
    .start    (qual_start_ff),
    .mclk_lvl (mclk_l),
    .done     (qual_done),
    .pass     (qual_pass)
  );

  // Start-up runs on the internal clock; qualification decides handover.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ACS_ST_STARTUP: if (startup_end) nxt_state = ACS_ST_QUALIFY;
      ACS_ST_QUALIFY: if (qual_done) nxt_state = qual_pass ? ACS_ST_RUN_EXT : ACS_ST_FAULT;
      ACS_ST_RUN_EXT: nxt_state = ACS_ST_RUN_EXT;
      ACS_ST_FAULT:   nxt_state = ACS_ST_FAULT;
      default:        nxt_state = ACS_ST_STARTUP;
    endcase
  end

  always_ff @(posedge clock or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      state_ff       <= ACS_ST_STARTUP;
      startup_cnt_ff <= 16'h0000;
      strap_done_ff  <= 1'b0;
      clk_sel_ff     <= 1'b0;
      spi_mode_ff    <= 1'b0;
      qual_start_ff  <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      qual_start_ff <= startup_end;
      if (state_ff == ACS_ST_STARTUP)
        startup_cnt_ff <= startup_cnt_ff + 16'h0001;
      if (startup_end)
      begin
        strap_done_ff <= 1'b1;
        clk_sel_ff    <= clksel_l;
        spi_mode_ff   <= ctrl_l;
      end
    end
  end

  // Serial port: 16-bit frames, read flag, 7-bit address, 8-bit data.
  logic        sclk_prev_ff;
  logic [4:0]  bit_cnt_ff;
  logic [15:0] shin_ff;
  logic [7:0]  shout_ff;
  logic        sdo_ff;
  logic        sdo_oe_ff;
  wire         rise = ~cs_l & sclk_l & ~sclk_prev_ff;
  wire         fall = ~cs_l & ~sclk_l & sclk_prev_ff;
  wire         rd_go = rise && bit_cnt_ff == 5'h07 && shin_ff[6];
  wire  [6:0]  raddr = {shin_ff[5:0], sdi_l};
  wire         wr_stb = rise && bit_cnt_ff == 5'h0F && !shin_ff[14] && spi_mode_ff;
  wire  [6:0]  waddr = shin_ff[13:7];
  wire  [7:0]  wdata = {shin_ff[6:0], sdi_l};

  logic [7:0] pwr_clk_ff;
  logic [7:0] gen_cfg_ff;
  logic [7:0] ch_stby_ff;
  logic [7:0] filt_ff;
  logic [7:0] decim_reg_ff;
  logic [7:0] ref_pc_ff;
  logic [7:0] gpio_ff;
  logic       clk_err_ff;
  logic       ext_clk_sel_ff;

  wire [7:0] status_w = {6'h00, ext_clk_sel_ff, clk_err_ff};
  wire [7:0] rdata = (raddr == `ACS_ADDR_PWR_CLK) ? pwr_clk_ff :
                     (raddr == `ACS_ADDR_GEN_CFG) ? gen_cfg_ff :
                     (raddr == `ACS_ADDR_CH_STBY) ? ch_stby_ff :
                     (raddr == `ACS_ADDR_FILT)    ? filt_ff :
                     (raddr == `ACS_ADDR_DECIM)   ? decim_reg_ff :
                     (raddr == `ACS_ADDR_REF_PC)  ? ref_pc_ff :
                     (raddr == `ACS_ADDR_GPIO)    ? gpio_ff :
                     (raddr == `ACS_ADDR_STATUS)  ? status_w : 8'h00;

  always_ff @(posedge clock or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      sclk_prev_ff <= 1'b0;
      bit_cnt_ff   <= 5'h00;
      shin_ff      <= 16'h0000;
      shout_ff     <= 8'h00;
      sdo_ff       <= 1'b0;
      sdo_oe_ff    <= 1'b0;
    end
    else
    begin
      sclk_prev_ff <= sclk_l;
      sdo_oe_ff    <= ~cs_l;
      if (cs_l)
        bit_cnt_ff <= 5'h00;
      else if (rise)
      begin
        shin_ff    <= {shin_ff[14:0], sdi_l};
        bit_cnt_ff <= (bit_cnt_ff == 5'h0F) ? 5'h00 : bit_cnt_ff + 5'h01;
      end
      if (rd_go)
        shout_ff <= rdata;
      else if (fall && bit_cnt_ff >= 5'h08)
      begin
        sdo_ff   <= shout_ff[7];
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
    end
  end

  // Register writes; decimation codes above the sixth rate are ignored.
  always_ff @(posedge clock or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      pwr_clk_ff   <= `ACS_RST_PWR_CLK;
      gen_cfg_ff   <= `ACS_RST_GEN_CFG;
      ch_stby_ff   <= `ACS_RST_CH_STBY;
      filt_ff      <= `ACS_RST_FILT;
      decim_reg_ff <= `ACS_RST_DECIM;
      ref_pc_ff    <= `ACS_RST_REF_PC;
      gpio_ff      <= `ACS_RST_GPIO;
    end
    else if (wr_stb)
    begin
      if (waddr == `ACS_ADDR_PWR_CLK) pwr_clk_ff <= wdata;
      else if (waddr == `ACS_ADDR_GEN_CFG) gen_cfg_ff <= wdata;
      else if (waddr == `ACS_ADDR_CH_STBY) ch_stby_ff <= wdata;
      else if (waddr == `ACS_ADDR_FILT) filt_ff <= wdata;
      else if (waddr == `ACS_ADDR_DECIM && decim_ok(wdata[2:0])) decim_reg_ff <= wdata;
      else if (waddr == `ACS_ADDR_REF_PC) ref_pc_ff <= wdata;
      else if (waddr == `ACS_ADDR_GPIO) gpio_ff <= wdata;
    end
  end

  wire           gpio_out   = gpio_ff[`ACS_GPIO_DIR_BIT];
  wire           diff_way1  = gpio_out && pwr_clk_ff[`ACS_PWR_DIFF_BIT];
  wire           diff_way2  = !gpio_out && !dpin_l && pwr_clk_ff[`ACS_PWR_DIFF_BIT];
  wire           nxt_diff   = spi_mode_ff && clk_sel_ff && (diff_way1 || diff_way2);
  wire           nxt_xtal   = clk_sel_ff && !nxt_diff && !ch_stby_ff[XCH];
  wire           nxt_cm_en  = (spi_mode_ff ? gen_cfg_ff[`ACS_GEN_CM_EN_BIT] : 1'b1)
                              && !ch_stby_ff[0];
  wire     [1:0] nxt_cm_lvl = spi_mode_ff ? gen_cfg_ff[1:0] : 2'(ACS_CM_HALF);
  wire     [7:0] nxt_ref_pc = spi_mode_ff ? ref_pc_ff : 8'h00;
  wire [NCH-1:0] nxt_filt   = spi_mode_ff ? filt_ff[NCH-1:0] : {NCH{filt_l}};
  wire     [2:0] nxt_decim  = spi_mode_ff ? decim_reg_ff[2:0] :
                              (decim_ok(decim_l) ? decim_l : 3'h0);

  logic           err_hdr_ff;
  logic           conv_en_ff;
  logic           diff_ff;
  logic           xtal_ff;
  logic           cm_en_ff;
  logic [1:0]     cm_lvl_ff;
  logic [7:0]     ref_pc_out_ff;
  logic [NCH-1:0] filt_out_ff;
  logic [2:0]     decim_out_ff;
  logic [NCH-1:0] stby_out_ff;
  logic           gpio_oe_ff;
  logic           gpio_o_ff;

  always_ff @(posedge clock or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      clk_err_ff     <= 1'b0;
      err_hdr_ff     <= 1'b0;
      ext_clk_sel_ff <= 1'b0;
      conv_en_ff     <= 1'b0;
      diff_ff        <= 1'b0;
      xtal_ff        <= 1'b0;
      cm_en_ff       <= 1'b0;
      cm_lvl_ff      <= 2'h0;
      ref_pc_out_ff  <= 8'h00;
      filt_out_ff    <= '0;
      decim_out_ff   <= 3'h0;
      stby_out_ff    <= '0;
      gpio_oe_ff     <= 1'b0;
      gpio_o_ff      <= 1'b0;
    end
    else
    begin
      clk_err_ff     <= state_ff == ACS_ST_FAULT;
      err_hdr_ff     <= state_ff == ACS_ST_FAULT;
      ext_clk_sel_ff <= state_ff == ACS_ST_RUN_EXT;
      conv_en_ff     <= state_ff == ACS_ST_RUN_EXT;
      diff_ff        <= nxt_diff;
      xtal_ff        <= nxt_xtal;
      cm_en_ff       <= strap_done_ff && nxt_cm_en;
      cm_lvl_ff      <= nxt_cm_lvl;
      ref_pc_out_ff  <= nxt_ref_pc;
      filt_out_ff    <= nxt_filt;
      decim_out_ff   <= nxt_decim;
      stby_out_ff    <= ch_stby_ff[NCH-1:0];
      gpio_oe_ff     <= spi_mode_ff && gpio_out;
      gpio_o_ff      <= gpio_ff[`ACS_GPIO_OUT_BIT];
    end
  end

  assign sdo                      = sdo_ff;
  assign sdo_oe                   = sdo_oe_ff;
  assign ext_clk_sel              = ext_clk_sel_ff;
  assign clk_err                  = clk_err_ff;
  assign status_hdr_err           = err_hdr_ff;
  assign conv_data_en             = conv_en_ff;
  assign diff_clk_en              = diff_ff;
  assign xtal_excite_en           = xtal_ff;
  assign common_mode_output_en    = cm_en_ff;
  assign common_mode_output_level = cm_lvl_ff;
  assign ref_prechg_en            = ref_pc_out_ff;
  assign filter_type              = filt_out_ff;
  assign decim_sel                = decim_out_ff;
  assign chan_standby             = stby_out_ff;
  assign diff_clock_mode_pin_oe   = gpio_oe_ff;
  assign diff_clock_mode_pin_o    = gpio_o_ff;

  sequence s_qual_fail;
    state_ff == ACS_ST_QUALIFY && qual_done && !qual_pass;
  endsequence
  sequence s_qual_ok;
    state_ff == ACS_ST_QUALIFY && qual_done && qual_pass;
  endsequence

  property p_startup_len;
    @(posedge clock) disable iff (!rst_core_n)
    (state_ff == ACS_ST_QUALIFY && $past(state_ff) == ACS_ST_STARTUP)
      |-> $past(startup_cnt_ff) == 16'(`ACS_STARTUP_CYC - 1);
  endproperty
  a_startup_len: assert property (p_startup_len) else $error("Start-up length wrong.");
  property p_handover_ok;
    @(posedge clock) disable iff (!rst_core_n)
    s_qual_ok |=> ##1 (ext_clk_sel_ff && conv_en_ff && !clk_err_ff);
  endproperty
  a_handover_ok: assert property (p_handover_ok) else $error("No handover after pass.");
  property p_fail_flag;
    @(posedge clock) disable iff (!rst_core_n)
    s_qual_fail |=> ##1 (clk_err_ff && err_hdr_ff && !ext_clk_sel_ff);
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("Fault not flagged.");
  property p_fault_hold;
    @(posedge clock) disable iff (!rst_core_n)
    clk_err_ff |=> clk_err_ff && !conv_en_ff && !ext_clk_sel_ff;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("Fault state left or data out.");
  property p_cmos_only;
    @(posedge clock) disable iff (!rst_core_n)
    (strap_done_ff && !clk_sel_ff) |=> !xtal_ff && !diff_ff;
  endproperty
  a_cmos_only: assert property (p_cmos_only) else $error("Crystal path with strap low.");
  property p_diff_spi;
    @(posedge clock) disable iff (!rst_core_n)
    diff_ff |-> spi_mode_ff && clk_sel_ff && !xtal_ff;
  endproperty
  a_diff_spi: assert property (p_diff_spi) else $error("Differential clock illegal.");
  property p_cm_ch0;
    @(posedge clock) disable iff (!rst_core_n)
    ch_stby_ff[0] |=> !cm_en_ff;
  endproperty
  a_cm_ch0: assert property (p_cm_ch0) else $error("Common-mode on with channel 0 idle.");
  property p_strap_defaults;
    @(posedge clock) disable iff (!rst_core_n)
    (strap_done_ff && !spi_mode_ff && !ch_stby_ff[0]) |=> cm_en_ff
      && cm_lvl_ff == 2'(ACS_CM_HALF) && ref_pc_out_ff == 8'h00;
  endproperty
  a_strap_defaults: assert property (p_strap_defaults) else $error("Strap defaults wrong.");
  property p_filter_shared;
    @(posedge clock) disable iff (!rst_core_n)
    (strap_done_ff && !spi_mode_ff) |=> (filt_out_ff == '0 || &filt_out_ff);
  endproperty
  a_filter_shared: assert property (p_filter_shared) else $error("Mixed filters in strap mode.");
  property p_decim_range;
    @(posedge clock) disable iff (!rst_core_n)
    decim_out_ff <= `ACS_DECIM_MAX;
  endproperty
  a_decim_range: assert property (p_decim_range) else $error("Decimation code out of range.");
endmodule
`default_nettype wire

// ### hw/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

`define ACS_CLK_PERIOD_NS 50
`define ACS_STARTUP_NS 10000
`define ACS_STARTUP_CYC (`ACS_STARTUP_NS / `ACS_CLK_PERIOD_NS)
`define ACS_QUAL_WIN_NS 50000
`define ACS_QUAL_WIN_CYC (`ACS_QUAL_WIN_NS / `ACS_CLK_PERIOD_NS)
`define ACS_MCLK_MIN_KHZ 1150
`define ACS_QUAL_THR ((`ACS_MCLK_MIN_KHZ * `ACS_QUAL_WIN_NS) / 1000000 + 2)

`define ACS_ADDR_PWR_CLK 7'h04
`define ACS_ADDR_GEN_CFG 7'h05
`define ACS_ADDR_CH_STBY 7'h08
`define ACS_ADDR_FILT 7'h09
`define ACS_ADDR_DECIM 7'h0A
`define ACS_ADDR_REF_PC 7'h0B
`define ACS_ADDR_GPIO 7'h0C
`define ACS_ADDR_STATUS 7'h0D

`define ACS_PWR_DIFF_BIT 3
`define ACS_GEN_CM_EN_BIT 4
`define ACS_GPIO_DIR_BIT 0
`define ACS_GPIO_OUT_BIT 1
`define ACS_RST_PWR_CLK 8'h00
`define ACS_RST_GEN_CFG 8'h10
`define ACS_RST_CH_STBY 8'h00
`define ACS_RST_FILT 8'h00
`define ACS_RST_DECIM 8'h00
`define ACS_RST_REF_PC 8'h00
`define ACS_RST_GPIO 8'h00
`define ACS_DECIM_MAX 3'h5

`endif

// ### hw/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {ACS_ST_STARTUP, ACS_ST_QUALIFY, ACS_ST_RUN_EXT, ACS_ST_FAULT} acs_state_t;
  typedef enum logic [1:0] {ACS_CM_HALF, ACS_CM_1V65, ACS_CM_2V14, ACS_CM_2V5} acs_cm_level_t;
endpackage

// ### hw/acs_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sync3
  import acs_pkg::*;
#(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_lvl = (agree & s2_ff) | (~agree & lvl_ff);

  initial
  begin
    if (W < 1) $error("acs_sync3 width must be positive.");
  end

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      lvl_ff <= RST_VAL;
    end
    else
    begin
      s1_ff  <= d;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
  assign q = lvl_ff;
endmodule
`default_nettype wire

// ### hw/acs_clk_qual.sv
`timescale 1ns/1ps
`include "acs_map.svh"
`default_nettype none
module acs_clk_qual
  import acs_pkg::*;
#(
  parameter int WIN = `ACS_QUAL_WIN_CYC,
  parameter int THR = `ACS_QUAL_THR
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic mclk_lvl,
  output logic      done,
  output logic      pass
);
  logic        mclk_prev_ff;
  logic        active_ff;
  logic [15:0] win_ff;
  logic [15:0] edges_ff;
  logic        done_ff;
  logic        pass_ff;
  wire         fall = mclk_prev_ff & ~mclk_lvl;
  wire         last = active_ff && (win_ff == 16'(WIN - 1));
  wire  [15:0] nxt_edges = (fall && edges_ff != 16'hFFFF) ? edges_ff + 16'h0001 : edges_ff;
  logic        ref_prev_ff;
  logic        ref_run_ff;
  logic [15:0] ref_cyc_ff;
  logic [15:0] ref_edges_ff;
  wire         ref_fall = ref_prev_ff && !mclk_lvl;

  initial
  begin
    if (WIN < 1 || WIN > 65535 || THR < 1 || THR > 65535) $error("acs_clk_qual bad window.");
  end

  // Falling edges of the external clock are counted over a fixed window.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mclk_prev_ff <= 1'b0;
      active_ff    <= 1'b0;
      win_ff       <= 16'h0000;
      edges_ff     <= 16'h0000;
      done_ff      <= 1'b0;
      pass_ff      <= 1'b0;
    end
    else
    begin
      mclk_prev_ff <= mclk_lvl;
      done_ff      <= last;
      if (start)
      begin
        active_ff <= 1'b1;
        win_ff    <= 16'h0000;
        edges_ff  <= 16'h0000;
      end
      else if (active_ff)
      begin
        win_ff    <= win_ff + 16'h0001;
        edges_ff  <= nxt_edges;
        active_ff <= !last;
      end
      if (last)
        pass_ff <= (nxt_edges >= 16'(THR));
    end
  end
  assign done = done_ff;
  assign pass = pass_ff;

  // A separate count of window cycles and falling edges checks the verdict.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_prev_ff  <= 1'b0;
      ref_run_ff   <= 1'b0;
      ref_cyc_ff   <= 16'h0000;
      ref_edges_ff <= 16'h0000;
    end
    else
    begin
      ref_prev_ff <= mclk_lvl;
      if (start)
      begin
        ref_run_ff   <= 1'b1;
        ref_cyc_ff   <= 16'h0000;
        ref_edges_ff <= 16'h0000;
      end
      else if (ref_run_ff)
      begin
        ref_cyc_ff   <= ref_cyc_ff + 16'h0001;
        ref_edges_ff <= ref_edges_ff + {15'h0000, ref_fall};
        ref_run_ff   <= (ref_cyc_ff != 16'(WIN - 1));
      end
    end
  end

  property p_qual_thr;
    @(posedge clock) disable iff (!rst_n)
    done_ff |-> !ref_run_ff && ref_cyc_ff == 16'(WIN)
      && (pass_ff == (ref_edges_ff >= 16'(THR)));
  endproperty
  a_qual_thr: assert property (p_qual_thr) else $error("Qualification verdict does not match edge count.");
endmodule
`default_nettype wire

// ### bench/acs_mclk_src.sv
`timescale 1ns/1ps
`default_nettype none
module acs_mclk_src
(
  input  wire logic [15:0] half_ns,
  output logic             mclk
);
  // A zero half period models a missing clock: the pin then rests low.
  initial mclk = 1'b0;
  always
  begin
    if (half_ns != 16'h0000)
      #(half_ns) mclk = ~mclk;
    else
    begin
      mclk = 1'b0;
      #50;
    end
  end
endmodule
`default_nettype wire

// ### bench/adc_clock_select_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_clock_select_supervisor_tb_top;
  logic        clock, rst_n, mclk, clk_sel, ctrl_mode, filt_pin, gpio_drv, sclk, cs_n, sdi;
  logic        gpio_o, gpio_oe, gpio_pin, sdo, sdo_oe, ext_clk_sel, clk_err, hdr_err;
  logic        conv_en, diff_en, xtal_en, cm_en;
  logic [15:0] half_ns;
  logic [2:0]  decim_pin, decim;
  logic [1:0]  cm_lvl;
  logic [7:0]  prechg, filt, stby, rdat;
  logic        oe_mid;
  int          failures, comparisons;

  assign gpio_pin = gpio_oe ? gpio_o : gpio_drv;

  acs_top #(.NCH(8)) i_dut
  (
    .clock(clock), .rst_n(rst_n), .mclk_pin(mclk), .clk_sel_pin(clk_sel),
    .ctrl_mode_pin(ctrl_mode), .filter_pin(filt_pin), .decim_pin(decim_pin),
    .diff_clock_mode_pin_i(gpio_pin), .diff_clock_mode_pin_o(gpio_o),
    .diff_clock_mode_pin_oe(gpio_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .ext_clk_sel(ext_clk_sel), .clk_err(clk_err),
    .status_hdr_err(hdr_err), .conv_data_en(conv_en), .diff_clk_en(diff_en),
    .xtal_excite_en(xtal_en), .common_mode_output_en(cm_en),
    .common_mode_output_level(cm_lvl), .ref_prechg_en(prechg), .filter_type(filt),
    .decim_sel(decim), .chan_standby(stby)
  );

  acs_mclk_src i_mclk (.half_ns(half_ns), .mclk(mclk));

  initial clock = 1'b0;
  always #25 clock = ~clock;

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask

  // One serial frame; each clock phase lasts 8 cycles so the synchroniser keeps up.
  task automatic frame(input logic [15:0] w);
    cs_n = 1'b0;
    tick(8);
    for (int k = 0; k < 16; k++)
    begin
      sclk = 1'b0;
      sdi = w[15-k];
      tick(8);
      if (k >= 8)
        rdat[15-k] = sdo;
      if (k == 8)
        oe_mid = sdo_oe;
      sclk = 1'b1;
      tick(8);
    end
    cs_n = 1'b1;
    tick(10);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame({1'b0, a, d});
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    frame({1'b1, a, 8'h00});
    chk(rdat, exp);
    chk({6'h00, oe_mid, sdo_oe}, 8'h02);
  endtask

  task automatic boot(input logic cs, input logic sp, input logic [15:0] h);
    clk_sel = cs;
    ctrl_mode = sp;
    half_ns = h;
    rst_n = 1'b0;
    tick(10);
    rst_n = 1'b1;
    tick(100);
    chk({6'h00, ext_clk_sel, conv_en}, 8'h00);
    for (int n = 0; n < 1500 && ext_clk_sel !== 1'b1 && clk_err !== 1'b1; n++)
      tick(1);
    tick(2);
  endtask

  function automatic logic [7:0] flags();
    return {4'h0, ext_clk_sel, clk_err, hdr_err, conv_en};
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #2000000;
    failures++;
    end_of_test();
  end

  initial
  begin
    failures = 0;
    comparisons = 0;
    rst_n = 1'b0;
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
    clk_sel = 1'b0;
    ctrl_mode = 1'b1;
    filt_pin = 1'b0;
    decim_pin = 3'h0;
    gpio_drv = 1'b0;
    half_ns = 16'h0000;
    boot(1'b0, 1'b1, 16'h007D);
    chk({6'h00, diff_en, xtal_en}, 8'h00);
    chk(flags(), 8'h09);
    rchk(7'h0D, 8'h02);
    for (int l = 0; l < 4; l++)
    begin
      wr(7'h05, 8'h10 | l[7:0]);
      chk({5'h00, cm_en, cm_lvl}, 8'h04 | l[7:0]);
    end
    wr(7'h05, 8'h03);
    chk({5'h00, cm_en, cm_lvl}, 8'h03);
    wr(7'h05, 8'h13);
    rchk(7'h05, 8'h13);
    wr(7'h08, 8'h01);
    chk({7'h00, cm_en}, 8'h00);
    chk(stby, 8'h01);
    wr(7'h08, 8'h00);
    chk({7'h00, cm_en}, 8'h01);
    wr(7'h09, 8'hA5);
    chk(filt, 8'hA5);
    rchk(7'h09, 8'hA5);
    for (int d = 0; d < 6; d++)
    begin
      wr(7'h0A, d[7:0]);
      chk({5'h00, decim}, d[7:0]);
    end
    wr(7'h0A, 8'h06);
    chk({5'h00, decim}, 8'h05);
    wr(7'h0B, 8'h3C);
    chk(prechg, 8'h3C);
    rchk(7'h30, 8'h00);
    $display("test serial registers done");
    boot(1'b1, 1'b1, 16'h007D);
    chk(flags(), 8'h09);
    chk({6'h00, diff_en, xtal_en}, 8'h01);
    wr(7'h08, 8'h10);
    chk({6'h00, diff_en, xtal_en}, 8'h00);
    wr(7'h08, 8'h00);
    wr(7'h04, 8'h08);
    chk({6'h00, diff_en, xtal_en}, 8'h02);
    wr(7'h04, 8'h00);
    wr(7'h0C, 8'h03);
    chk({6'h00, gpio_o, gpio_oe}, 8'h03);
    wr(7'h04, 8'h08);
    chk({7'h00, diff_en}, 8'h01);
    $display("test differential clock done");
    filt_pin = 1'b1;
    decim_pin = 3'h7;
    boot(1'b1, 1'b0, 16'h007D);
    chk({5'h00, cm_en, cm_lvl}, 8'h04);
    chk(prechg, 8'h00);
    chk(filt, 8'hFF);
    chk({5'h00, decim}, 8'h00);
    wr(7'h04, 8'h08);
    wr(7'h0B, 8'hFF);
    chk({7'h00, diff_en}, 8'h00);
    chk(prechg, 8'h00);
    $display("test strap mode done");
    for (int i = 0; i < 3; i++)
    begin
      boot(1'b0, 1'b1, (i == 0) ? 16'h0000 : (i == 1) ? 16'h01F4 : 16'h03E8);
      chk(flags(), 8'h06);
      rchk(7'h0D, 8'h01);
      tick(200);
      chk(flags(), 8'h06);
    end
    boot(1'b0, 1'b1, 16'h007D);
    chk(flags(), 8'h09);
    $display("test clock fault done");
    end_of_test();
  end
endmodule
`default_nettype wire
